// ===== hspc_sleep_ctrl.sv
// How it works
// - Awake pin, when selected, is low asleep and high awake in any sleep.
// - With flow control on, CTS goes high on entering sleep.
// - With flow control on, CTS goes low on wake.
// - Serial and radio data are ignored while asleep.
// - UART pin sleep without sleep-request pin selected never sleeps.
// - Sleep-request high sleeps, low wakes.
// - SPI: after init raise attention and send a status frame.
// - Attention shows pending data for the master while awake, and also rises after init in SPI.
// - SPI with sleep pin config peripheral uses sleep-request pin.
// - SPI otherwise uses chip select as pin-sleep control.
// - Chip-select control sleeps whenever the master negates chip select.
// - Mode selects pin or cyclic sleep; option selects the level.
// - Associated and deep sleep levels supported in both modes.
// - Cyclic associated sleep wakes for a 30 ms window at the end of each period.
// - Wake-host delay holds data output; indicators change at once.
`timescale 1ns/1ps
module hspc_sleep_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic spiMode,
  input wire logic [2:0] flow_control_pin_config,
  input wire logic [2:0] sleep_pin_config,
  input wire logic [2:0] awake_pin_config,
  input wire logic [1:0] sleep_mode_select,
  input wire logic sleepOption,
  input wire logic [hspc_pkg::CntW-1:0] sleep_period,
  input wire logic [hspc_pkg::CntW-1:0] wake_time,
  input wire logic [hspc_pkg::CntW-1:0] wake_host_delay,
  input wire logic sleep_request_pin,
  input wire logic spiSelectN,
  input wire logic initDone,
  input wire logic dataPending,
  input wire logic serialRxValid,
  input wire logic radioRxValid,
  input wire logic activity,
  output logic awakePin,
  output logic ctsN,
  output logic attention_pin,
  output logic statusFrameReq,
  output logic acceptData,
  output logic sendEnable,
  output logic radioPowered,
  output logic deepSleep
);
  logic [1:0] syncIn;
  logic sleepReqSync;
  logic selectNSync;
  logic pinCtrl;
  logic pinSleepReq;
  logic canPinSleep;
  logic cyclic;
  logic flowOn;
  logic awakeFn;
  logic isAwake;
  logic wokeNow;
  logic holdDone;
  logic rxSeen;
  hspc_pkg::hspc_state_e state_q, state_d;
  logic [hspc_pkg::CntW-1:0] period_q;
  logic [hspc_pkg::CntW-1:0] hold_q;
  logic [hspc_pkg::CntW-1:0] win_q;
  logic inited_q;
  logic activeSeen_q;
  logic awakePin_q, ctsN_q, attn_q, frame_q, accept_q, send_q, radio_q, deep_q;

  hspc_timer_if tmrBus ();

  hspc_sync u_sync (
    .clk(clk),
    .srst(srst),
    .asyncIn({spiSelectN, sleep_request_pin}),
    .syncOut(syncIn)
  );

  hspc_timer u_timer (
    .clk(clk),
    .srst(srst),
    .tmr(tmrBus)
  );

  assign sleepReqSync = syncIn[0];
  assign selectNSync = syncIn[1];
  assign flowOn = (flow_control_pin_config == hspc_pkg::PinFuncPeripheral);
  assign awakeFn = (awake_pin_config == hspc_pkg::PinFuncPeripheral);
  assign pinCtrl = (sleep_pin_config == hspc_pkg::PinFuncPeripheral);
  // SPI picks the sleep-request pin if selected, else chip select
  assign pinSleepReq = spiMode ? (pinCtrl ? sleepReqSync : selectNSync)
                               : sleepReqSync;
  assign canPinSleep = (sleep_mode_select == hspc_pkg::SleepModePin) && (spiMode || pinCtrl);
  assign cyclic = (sleep_mode_select == hspc_pkg::SleepModeCyclic);
  assign isAwake = (state_d != hspc_pkg::HSPC_ST_SLEEP) && (state_d != hspc_pkg::HSPC_ST_INIT);
  assign wokeNow = (state_q == hspc_pkg::HSPC_ST_SLEEP) && isAwake;
  assign holdDone = (hold_q == '0);
  assign rxSeen = serialRxValid || radioRxValid || activity;
  assign tmrBus.start = 1'b0;
  assign tmrBus.load = '0;

  always_comb begin
    state_d = state_q;
    case (state_q)
      hspc_pkg::HSPC_ST_INIT: begin
        if (initDone) begin
          state_d = hspc_pkg::HSPC_ST_AWAKE;
        end
      end
      hspc_pkg::HSPC_ST_AWAKE, hspc_pkg::HSPC_ST_HOLD: begin
        if (canPinSleep && pinSleepReq) begin
          state_d = hspc_pkg::HSPC_ST_SLEEP;
        end else if (cyclic && win_q == '0) begin
          state_d = hspc_pkg::HSPC_ST_SLEEP;
        end
      end
      hspc_pkg::HSPC_ST_WINDOW: begin
        // Short look for traffic; stay for the wake time only if some arrived
        if (activeSeen_q) begin
          state_d = hspc_pkg::HSPC_ST_HOLD;
        end else if (win_q == '0) begin
          state_d = hspc_pkg::HSPC_ST_SLEEP;
        end
      end
      hspc_pkg::HSPC_ST_SLEEP: begin
        if (canPinSleep && !pinSleepReq) begin
          state_d = hspc_pkg::HSPC_ST_AWAKE;
        end else if (!canPinSleep && !cyclic) begin
          state_d = hspc_pkg::HSPC_ST_AWAKE;
        end else if (cyclic && period_q == '0) begin
          state_d = hspc_pkg::HSPC_ST_WINDOW;
        end
      end
      default: state_d = hspc_pkg::HSPC_ST_INIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= hspc_pkg::HSPC_ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Sleep period counts microsecond ticks; window counts cycles
  always_ff @(posedge clk) begin
    if (srst) begin
      period_q <= '0;
      win_q <= '0;
      activeSeen_q <= 1'b0;
    end else begin
      if (state_d == hspc_pkg::HSPC_ST_SLEEP && state_q != hspc_pkg::HSPC_ST_SLEEP) begin
        period_q <= sleep_period;
      end else if (tmrBus.tick && period_q != '0) begin
        period_q <= period_q - 1'b1;
      end
      if (state_d == hspc_pkg::HSPC_ST_WINDOW && state_q != hspc_pkg::HSPC_ST_WINDOW) begin
        win_q <= hspc_pkg::CntW'(hspc_pkg::WakeWindowCycles);
      end else if (state_d == hspc_pkg::HSPC_ST_HOLD && state_q == hspc_pkg::HSPC_ST_WINDOW) begin
        win_q <= wake_time;
      end else if (state_q == hspc_pkg::HSPC_ST_INIT) begin
        win_q <= wake_time;
      end else if (win_q != '0 && (state_q == hspc_pkg::HSPC_ST_WINDOW || tmrBus.tick)) begin
        win_q <= win_q - 1'b1;
      end
      activeSeen_q <= (state_q == hspc_pkg::HSPC_ST_WINDOW) && rxSeen;
    end
  end

  // Wake-host hold only delays data, never the indicators
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_q <= '0;
    end else if (wokeNow) begin
      hold_q <= wake_host_delay;
    end else if (!holdDone && tmrBus.tick) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      awakePin_q <= hspc_pkg::AwakeIdle;
      ctsN_q <= hspc_pkg::CtsIdle;
      attn_q <= 1'b0;
      frame_q <= 1'b0;
      accept_q <= 1'b0;
      send_q <= 1'b0;
      radio_q <= 1'b0;
      deep_q <= 1'b0;
      inited_q <= 1'b0;
    end else begin
      awakePin_q <= awakeFn ? isAwake : hspc_pkg::AwakeIdle;
      ctsN_q <= flowOn ? !isAwake : !hspc_pkg::CtsIdle;
      inited_q <= inited_q || (state_q == hspc_pkg::HSPC_ST_INIT && initDone);
      frame_q <= spiMode && state_q == hspc_pkg::HSPC_ST_INIT && initDone;
      attn_q <= spiMode && isAwake && (dataPending || (state_q == hspc_pkg::HSPC_ST_INIT && initDone));
      accept_q <= isAwake;
      send_q <= isAwake && holdDone && !wokeNow;
      // Deep sleep drops the radio; associated sleep keeps it for beacons
      radio_q <= isAwake || (sleepOption == hspc_pkg::SleepOptAssoc);
      deep_q <= !isAwake && (sleepOption == hspc_pkg::SleepOptDeep);
    end
  end

  assign awakePin = awakePin_q;
  assign ctsN = ctsN_q;
  assign attention_pin = attn_q;
  assign statusFrameReq = frame_q;
  assign acceptData = accept_q;
  assign sendEnable = send_q;
  assign radioPowered = radio_q;
  assign deepSleep = deep_q;

  chk_cts_sleep: assert property (@(posedge clk) disable iff (srst)
    flowOn && $past(flowOn) && state_q == hspc_pkg::HSPC_ST_SLEEP && $past(state_q) == hspc_pkg::HSPC_ST_SLEEP
    |-> ctsN) else $error("CTS low while asleep");
  chk_cts_wake: assert property (@(posedge clk) disable iff (srst)
    flowOn && state_q == hspc_pkg::HSPC_ST_SLEEP && state_d == hspc_pkg::HSPC_ST_AWAKE
    ##1 flowOn |-> !ctsN) else $error("CTS not low after wake");
  chk_awake_pin: assert property (@(posedge clk) disable iff (srst)
    awakeFn ##1 awakeFn |-> awakePin == $past(isAwake)) else $error("Awake pin wrong");
  chk_no_rx_asleep: assert property (@(posedge clk) disable iff (srst)
    state_q == hspc_pkg::HSPC_ST_SLEEP && $past(state_q) == hspc_pkg::HSPC_ST_SLEEP |-> !acceptData && !sendEnable)
    else $error("Data accepted while asleep");
  chk_uart_nosleep: assert property (@(posedge clk) disable iff (srst)
    !spiMode && !pinCtrl && sleep_mode_select == hspc_pkg::SleepModePin && state_q != hspc_pkg::HSPC_ST_SLEEP
    |=> state_q != hspc_pkg::HSPC_ST_SLEEP) else $error("Slept without sleep pin");
  chk_pin_sleep: assert property (@(posedge clk) disable iff (srst)
    canPinSleep && pinSleepReq && state_q == hspc_pkg::HSPC_ST_AWAKE |=> state_q == hspc_pkg::HSPC_ST_SLEEP)
    else $error("Sleep request ignored");
  chk_cs_sleep: assert property (@(posedge clk) disable iff (srst)
    spiMode && !pinCtrl && canPinSleep && selectNSync && state_q == hspc_pkg::HSPC_ST_AWAKE
    |=> state_q == hspc_pkg::HSPC_ST_SLEEP) else $error("Chip select negate did not sleep");
  chk_init_frame: assert property (@(posedge clk) disable iff (srst)
    spiMode && state_q == hspc_pkg::HSPC_ST_INIT && initDone |=> statusFrameReq && attention_pin)
    else $error("No status frame after init");
  chk_hold_data: assert property (@(posedge clk) disable iff (srst)
    wokeNow && wake_host_delay != '0 |=> !sendEnable) else $error("Data sent during wake hold");
  chk_window_len: assert property (@(posedge clk) disable iff (srst)
    state_q == hspc_pkg::HSPC_ST_SLEEP && state_d == hspc_pkg::HSPC_ST_WINDOW |=> win_q != '0)
    else $error("Wake window not loaded");
endmodule

// ===== hspc_pkg.sv
package hspc_pkg;
  // Time figures and derived counts at the 10 MHz core rate
  localparam int unsigned ClkPeriodNs = 100;
  localparam int unsigned WakeWindowMs = 30;
  localparam int unsigned WakeWindowCycles = (WakeWindowMs * 1000000) / ClkPeriodNs;
  localparam int unsigned TickUs = 1;
  localparam int unsigned TickCycles = (TickUs * 1000) / ClkPeriodNs;
  localparam int unsigned CntW = 24;
  localparam int unsigned TickW = 4;

  // Pin function codes for the configurable pins
  localparam logic [2:0] PinFuncDisabled = 3'h0;
  localparam logic [2:0] PinFuncPeripheral = 3'h1;

  // Sleep mode select
  localparam logic [1:0] SleepModeNone = 2'h0;
  localparam logic [1:0] SleepModePin = 2'h1;
  localparam logic [1:0] SleepModeCyclic = 2'h2;

  // Sleep option: associated or deep
  localparam logic SleepOptAssoc = 1'b0;
  localparam logic SleepOptDeep = 1'b1;

  // Reset values of the outputs
  localparam logic CtsIdle = 1'b1;
  localparam logic AwakeIdle = 1'b0;

  typedef enum logic [2:0] {
    HSPC_ST_INIT   = 3'b000,
    HSPC_ST_AWAKE  = 3'b001,
    HSPC_ST_SLEEP  = 3'b010,
    HSPC_ST_WINDOW = 3'b011,
    HSPC_ST_HOLD   = 3'b100
  } hspc_state_e;
endpackage

// ===== hspc_timer_if.sv
`timescale 1ns/1ps
interface hspc_timer_if;
  logic start;
  logic [hspc_pkg::CntW-1:0] load;
  logic expired;
  logic tick;
  modport owner (output start, output load, input expired, input tick);
  modport timer (input start, input load, output expired, output tick);
endinterface

// ===== hspc_sync.sv
`timescale 1ns/1ps
module hspc_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] asyncIn,
  output logic [1:0] syncOut
);
  logic [1:0] stage1_q;
  logic [1:0] stage2_q;

  // Inputs that feed sleep decisions pass two flops first
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1_q <= 2'h0;
      stage2_q <= 2'h0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;
endmodule

// ===== hspc_timer.sv
`timescale 1ns/1ps
module hspc_timer (
  input wire logic clk,
  input wire logic srst,
  hspc_timer_if.timer tmr
);
  logic [hspc_pkg::TickW-1:0] div_q;
  logic [hspc_pkg::CntW-1:0] cnt_q;
  logic running_q;
  logic tickNow;

  // One-cycle enable every microsecond for the slow period counters
  assign tickNow = (div_q == hspc_pkg::TickW'(hspc_pkg::TickCycles - 1));
  assign tmr.tick = tickNow;
  assign tmr.expired = running_q && (cnt_q == '0);

  always_ff @(posedge clk) begin
    if (srst) begin
      div_q <= '0;
    end else begin
      div_q <= tickNow ? '0 : div_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      running_q <= 1'b0;
    end else if (tmr.start) begin
      cnt_q <= tmr.load;
      running_q <= 1'b1;
    end else if (running_q && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ===== hspc_host_model.sv
`timescale 1ns/1ps
module hspc_host_model (
  input wire logic ctsN,
  input wire logic sleepCmd,
  input wire logic useSel,
  input wire logic sendCmd,
  output logic sleepPin,
  output logic selN,
  output logic serialValid
);
  // With chip select as sleep control the host keeps the sleep pin low
  assign sleepPin = sleepCmd & ~useSel;
  // Negating chip select is how this host asks for sleep
  assign selN = sleepCmd & useSel;
  // Serial data only goes out while the device offers CTS
  assign serialValid = sendCmd & ~ctsN;
endmodule

// ===== tb_hspc_sleep_ctrl.sv
`timescale 1ns/1ps
module tb_hspc_sleep_ctrl;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic spiMode = 1'h0;
  logic [2:0] flowCfg = 3'h1;
  logic [2:0] sleepCfg = 3'h1;
  logic [1:0] modeSel = hspc_pkg::SleepModePin;
  logic sleepOpt = hspc_pkg::SleepOptAssoc;
  logic [hspc_pkg::CntW-1:0] hostDelay = 24'h00_0000;
  logic initDone = 1'h0;
  logic dataPending = 1'h0;
  logic radioRx = 1'h0;
  logic sleepCmd = 1'h0;
  logic useSel = 1'h0;
  logic sendCmd = 1'h1;
  logic sleepPin, selN, serRx;
  logic awakePin, ctsN, attn, frameReq, acceptData, sendEnable, deepSleep, radioPwr;
  int errTotal = 0;
  int testsRun = 0;
  int frames;

  always #50 clk = ~clk;

  hspc_host_model u_host (.ctsN(ctsN), .sleepCmd(sleepCmd), .useSel(useSel), .sendCmd(sendCmd),
    .sleepPin(sleepPin), .selN(selN), .serialValid(serRx));

  hspc_sleep_ctrl u_dut (.clk(clk), .srst(srst), .spiMode(spiMode), .flow_control_pin_config(flowCfg),
    .sleep_pin_config(sleepCfg), .awake_pin_config(3'h1), .sleep_mode_select(modeSel),
    .sleepOption(sleepOpt), .sleep_period(24'h00_0010), .wake_time(24'h00_0010),
    .wake_host_delay(hostDelay), .sleep_request_pin(sleepPin), .spiSelectN(selN), .initDone(initDone),
    .dataPending(dataPending), .serialRxValid(serRx), .radioRxValid(radioRx), .activity(1'h0),
    .awakePin(awakePin), .ctsN(ctsN), .attention_pin(attn), .statusFrameReq(frameReq),
    .acceptData(acceptData), .sendEnable(sendEnable), .radioPowered(radioPwr), .deepSleep(deepSleep));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic chk(input string nm, input logic exp, input logic got);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // Reset with the present settings, then finish initialisation
  task automatic boot(input logic spi);
    sleepCmd = 1'h0;
    spiMode = spi;
    srst = 1'h1;
    cyc(3);
    chk("awakePin in reset", hspc_pkg::AwakeIdle, awakePin);
    chk("ctsN in reset", hspc_pkg::CtsIdle, ctsN);
    srst = 1'h0;
    initDone = 1'h1;
    cyc(1);
    initDone = 1'h0;
    frames = 0;
    // The frame pulse stands only in the cycle right after init, so sample before stepping
    repeat (20) begin
      frames += (frameReq === 1'h1);
      cyc(1);
    end
  endtask

  // Pin changes take three cycles to reach the outputs
  task automatic setSleep(input logic s);
    sleepCmd = s;
    cyc(6);
  endtask

  task automatic stopTest;
    $display("Comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    $display("[FAIL] watchdog expected finish seen hang");
    stopTest();
  end

  initial begin
    boot(1'h0);
    chk("awakePin awake", 1'h1, awakePin);
    chk("ctsN awake", 1'h0, ctsN);
    chk("acceptData awake", 1'h1, acceptData);
    radioRx = 1'h1;
    setSleep(1'h1);
    chk("awakePin asleep", 1'h0, awakePin);
    chk("ctsN asleep", 1'h1, ctsN);
    chk("acceptData asleep", 1'h0, acceptData);
    chk("deepSleep assoc", 1'h0, deepSleep);
    chk("radioPowered assoc", 1'h1, radioPwr);
    setSleep(1'h0);
    chk("awakePin woken", 1'h1, awakePin);
    chk("ctsN woken", 1'h0, ctsN);
    sleepOpt = hspc_pkg::SleepOptDeep;
    setSleep(1'h1);
    chk("deepSleep deep", 1'h1, deepSleep);
    chk("radioPowered deep", 1'h0, radioPwr);
    setSleep(1'h0);
    chk("deepSleep woken", 1'h0, deepSleep);
    $display("uart pin sleep done");
    flowCfg = hspc_pkg::PinFuncDisabled;
    boot(1'h0);
    setSleep(1'h1);
    chk("ctsN flow off", 1'h0, ctsN);
    chk("awakePin flow off", 1'h0, awakePin);
    flowCfg = hspc_pkg::PinFuncPeripheral;
    sleepCfg = hspc_pkg::PinFuncDisabled;
    boot(1'h0);
    setSleep(1'h1);
    chk("awakePin no sleep pin", 1'h1, awakePin);
    sleepCfg = hspc_pkg::PinFuncPeripheral;
    modeSel = hspc_pkg::SleepModeNone;
    boot(1'h0);
    setSleep(1'h1);
    chk("awakePin mode none", 1'h1, awakePin);
    modeSel = hspc_pkg::SleepModePin;
    $display("uart config done");
    sleepCfg = hspc_pkg::PinFuncDisabled;
    useSel = 1'h1;
    boot(1'h1);
    chk("status frame pulse", 1'h1, frames == 1);
    dataPending = 1'h1;
    cyc(6);
    chk("attention data", 1'h1, attn);
    dataPending = 1'h0;
    cyc(6);
    chk("attention idle", 1'h0, attn);
    setSleep(1'h1);
    chk("awakePin select negated", 1'h0, awakePin);
    setSleep(1'h0);
    chk("awakePin select asserted", 1'h1, awakePin);
    sleepCfg = hspc_pkg::PinFuncPeripheral;
    useSel = 1'h0;
    boot(1'h1);
    setSleep(1'h1);
    chk("awakePin spi sleep pin", 1'h0, awakePin);
    $display("spi sleep done");
    hostDelay = 24'h00_0003;
    boot(1'h0);
    setSleep(1'h1);
    setSleep(1'h0);
    chk("awakePin wake host", 1'h1, awakePin);
    chk("sendEnable held", 1'h0, sendEnable);
    cyc(40);
    chk("sendEnable released", 1'h1, sendEnable);
    $display("wake host delay done");
    // Cyclic: wake time after init, then one sleep period, then a window that sees radio traffic
    sleepOpt = hspc_pkg::SleepOptAssoc;
    modeSel = hspc_pkg::SleepModeCyclic;
    boot(1'h0);
    chk("awakePin cyclic first wake", 1'h1, awakePin);
    cyc(170);
    chk("awakePin cyclic asleep", 1'h0, awakePin);
    cyc(160);
    chk("awakePin cyclic window hold", 1'h1, awakePin);
    $display("cyclic sleep done");
    stopTest();
  end
endmodule
